// ===== fpa_pkg.sv
// Constants shared by the program and data memory access block.
// Operation
// - Program-store pin low at reset: serial download.
// - Download mode writes the whole program array.
// - Program array fills low addresses from zero.
// - Data array: byte writes after 4-byte page erase.
// - Ports carry address, data, strobe and operation.
// - Port 3 bits select the parallel operation.
// - Top region writable only by download or parallel.
// - Lower region also writable by user download.
// - Protection flags are separate, independently set.
// - Lock blocks parallel program, still allows reads.
// - Secure blocks program, read, external table reads.
// - Only a code erase clears lock and secure.
// - Serial-safe turns download reset into normal reset.
// - Only parallel code erase clears serial-safe.
package fpa_pkg;
	// APB register byte offsets.
	localparam logic [7:0]  REG_ADDR   = 8'h00;
	localparam logic [7:0]  REG_DATA   = 8'h04;
	localparam logic [7:0]  REG_CMD    = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0C;
	// Memory map and erased cell value.
	localparam logic [15:0] PROG_LAST  = 16'hF7FF;
	localparam logic [15:0] USER_DL_LAST = 16'hDFFF;
	localparam logic [15:0] DATA_END   = 16'h1000;
	localparam int          PROG_BYTES = 63488;
	localparam int          DATA_BYTES = 4096;
	localparam logic [7:0]  ERASED     = 8'hFF;
	// Port 3 field positions.
	localparam int          P3_OP_LSB  = 1;
	localparam int          P3_CODE    = 4;
	// Parallel operation codes on port 3 bits 3..1.
	localparam logic [2:0]  OP_ERASE   = 3'h0;
	localparam logic [2:0]  OP_SIG     = 3'h1;
	localparam logic [2:0]  OP_PROG    = 3'h2;
	localparam logic [2:0]  OP_READ    = 3'h3;
	localparam logic [2:0]  OP_SECW    = 3'h4;
	localparam logic [2:0]  OP_SECR    = 3'h5;
	// Software command codes.
	localparam logic [2:0]  CMD_RD_DATA = 3'h1;
	localparam logic [2:0]  CMD_WR_DATA = 3'h2;
	localparam logic [2:0]  CMD_ER_PAGE = 3'h3;
	localparam logic [2:0]  CMD_RD_PROG = 3'h4;
	localparam logic [2:0]  CMD_WR_PROG = 3'h5;
	localparam logic [2:0]  CMD_ERASE   = 3'h6;
	localparam logic [2:0]  CMD_SEC_SET = 3'h7;
	// Status bit positions.
	localparam int          ST_ERR     = 0;
	localparam int          ST_BUSY    = 1;
	localparam int          ST_DL      = 2;
	localparam int          ST_LOCK    = 3;
	localparam int          ST_SECURE  = 4;
	localparam int          ST_SAFE    = 5;
	// Security byte bit positions.
	localparam int          SEC_LOCK   = 0;
	localparam int          SEC_SECURE = 1;
	localparam int          SEC_SAFE   = 2;
	// Erase sequencer states.
	typedef enum logic {ER_IDLE, ER_RUN} fpa_er_e;
endpackage

// ===== fpa_erase_seq.sv
// Address sweep that drives a full array erase one cell per cycle.
`timescale 1ns/1ps
`default_nettype none
module fpa_erase_seq
	import fpa_pkg::*;
#(
	parameter int SPAN = PROG_BYTES // Cells swept by one erase.
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	output logic             busy,
	output logic [15:0]      addr
);
	fpa_er_e     state_ff; // Sweep state.
	logic [15:0] cnt_ff;   // Cell being erased.

	// A sweep runs from cell zero to SPAN-1 and then returns to idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ER_IDLE;
			cnt_ff   <= 16'h0000;
		end else begin
			unique case (state_ff)
				ER_IDLE: if (start) begin
					state_ff <= ER_RUN;
					cnt_ff   <= 16'h0000;
				end
				ER_RUN: if (cnt_ff == 16'(SPAN - 1)) begin
					state_ff <= ER_IDLE;
				end else begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			endcase
		end
	end

	assign busy = (state_ff == ER_RUN);
	assign addr = cnt_ff;

	// The sweep must stop right after its last cell.
	a_erase_end: assert property (@(posedge pclk) disable iff (!presetn)
		busy && cnt_ff == 16'(SPAN - 1) |=> !busy)
		else $error("Erase sweep ran past its last cell.");
endmodule // fpa_erase_seq
`default_nettype wire

// ===== fpa_top.sv
// Flash program and data memory access, protection and parallel port.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fpa_top
	import fpa_pkg::*;
#(
	parameter int         ERASE_SPAN = PROG_BYTES, // Cycles of a full erase.
	parameter logic [7:0] SIGNATURE  = 8'h5A       // Arbitrary value.
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reset_pin_n,
	input  wire logic        program_store_enable_pin,
	input  wire logic        par_enable_pin,
	input  wire logic        ale_pin,
	input  wire logic [7:0]  port0_in,
	output logic [7:0]       port0_out,
	output logic             port0_oe,
	input  wire logic [7:0]  port1_in,
	input  wire logic [7:0]  port2_in,
	input  wire logic [7:0]  port3_in,
	input  wire logic        code_rd_req,
	input  wire logic        code_rd_ext,
	input  wire logic [15:0] code_rd_addr,
	output logic [7:0]       code_rd_data,
	output logic             code_rd_refused,
	output logic             serial_download_mode
);
	// Pin synchroniser; every pin passes two flops before use.
	logic [35:0] pin_raw;   // All asynchronous pins.
	logic [35:0] pin_s1_ff; // First stage, read only by the second.
	logic [35:0] pin_s2_ff; // Second stage, safe to use.
	logic [7:0]  p0_s, p1_s, p2_s, p3_s;
	logic        ale_s, par_en_s, pse_s, rst_pin_s;
	logic        ale_d_ff, rst_d_ff; // Edge detector history.
	logic        ale_rise, rst_rise;

	assign pin_raw = {reset_pin_n, program_store_enable_pin, par_enable_pin,
		ale_pin, port3_in, port2_in, port1_in, port0_in};

	// Reset values of zero make the first release look like a rising edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_ff <= 36'h0;
			pin_s2_ff <= 36'h0;
			ale_d_ff  <= 1'b0;
			rst_d_ff  <= 1'b0;
		end else begin
			pin_s1_ff <= pin_raw;
			pin_s2_ff <= pin_s1_ff;
			ale_d_ff  <= ale_s;
			rst_d_ff  <= rst_pin_s;
		end
	end

	assign p0_s      = pin_s2_ff[7:0];
	assign p1_s      = pin_s2_ff[15:8];
	assign p2_s      = pin_s2_ff[23:16];
	assign p3_s      = pin_s2_ff[31:24];
	assign ale_s     = pin_s2_ff[32];
	assign par_en_s  = pin_s2_ff[33];
	assign pse_s     = pin_s2_ff[34];
	assign rst_pin_s = pin_s2_ff[35];
	assign ale_rise  = ale_s & ~ale_d_ff; // Operation strobe edge.
	assign rst_rise  = rst_pin_s & ~rst_d_ff;

	// Protection flags and mode; presetn stands for power-on here.
	logic lock_ff, secure_ff, safe_ff, dl_mode_ff;
	logic er_busy, er_start, erase_data_ff;
	logic [15:0] er_addr;

	// Parallel port decode; the port 3 fields pick the operation.
	logic [2:0]  par_op;
	logic        par_code, par_go, par_prog_in, par_data_in;
	logic        par_prog_we, par_data_we, par_erase, par_secw;
	logic [15:0] par_addr;
	logic [7:0]  par_prog_rd, par_rd_val;

	assign par_op      = p3_s[P3_OP_LSB +: 3];
	assign par_code    = p3_s[P3_CODE];
	assign par_addr    = {p2_s, p1_s};
	assign par_go      = ale_rise & par_en_s & ~er_busy;
	assign par_prog_in = (par_addr <= PROG_LAST);
	assign par_data_in = (par_addr < DATA_END);
	// Lock and secure both refuse code programming.
	assign par_prog_we = par_go & (par_op == OP_PROG) & par_code
		& ~lock_ff & ~secure_ff & par_prog_in;
	assign par_data_we = par_go & (par_op == OP_PROG) & ~par_code
		& par_data_in;
	assign par_erase   = par_go & (par_op == OP_ERASE);
	assign par_secw    = par_go & (par_op == OP_SECW);

	// Software registers and command decode.
	logic [15:0] addr_ff;
	logic [7:0]  data_ff;
	logic [2:0]  cmd_ff;
	logic        cmd_go_ff, err_ff, cmd_ex;
	logic        sw_data_in, sw_prog_ok, sw_prog_we, sw_data_we;
	logic        sw_page_er, sw_erase, sw_secw, sw_bad;
	logic [9:0]  pg_idx;
	logic [7:0]  sw_prog_rd, table_rd_val;

	assign cmd_ex     = cmd_go_ff & ~er_busy;
	assign sw_data_in = (addr_ff < DATA_END);
	assign pg_idx     = addr_ff[11:2];
	// Upper region needs download mode; lower region is open.
	assign sw_prog_ok = (addr_ff <= PROG_LAST)
		& (dl_mode_ff | (addr_ff <= USER_DL_LAST));
	assign sw_prog_we = cmd_ex & (cmd_ff == CMD_WR_PROG) & sw_prog_ok;
	assign sw_data_we = cmd_ex & (cmd_ff == CMD_WR_DATA) & sw_data_in;
	assign sw_page_er = cmd_ex & (cmd_ff == CMD_ER_PAGE) & sw_data_in;
	assign sw_erase   = cmd_ex & (cmd_ff == CMD_ERASE) & dl_mode_ff;
	assign sw_secw    = cmd_ex & (cmd_ff == CMD_SEC_SET) & dl_mode_ff;
	assign sw_bad     = er_busy
		| ((cmd_ff == CMD_WR_PROG) & ~sw_prog_ok)
		| (((cmd_ff == CMD_RD_DATA) | (cmd_ff == CMD_WR_DATA)
			| (cmd_ff == CMD_ER_PAGE)) & ~sw_data_in)
		| (((cmd_ff == CMD_ERASE) | (cmd_ff == CMD_SEC_SET)) & ~dl_mode_ff);
	assign er_start   = par_erase | sw_erase;

	// Full erase sweep; parallel operations are ignored and software commands are refused with an error while it runs.
	fpa_erase_seq #(
		.SPAN (ERASE_SPAN)
	) u_erase (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (er_start),
		.busy    (er_busy),
		.addr    (er_addr)
	);

	// Arrays. Writes AND into the cell, so a byte programs only once erased.
	logic [7:0] prog_mem [0:PROG_BYTES-1];
	logic [7:0] data_mem [0:DATA_BYTES-1];

	assign par_prog_rd = par_prog_in ? prog_mem[par_addr] : ERASED;
	assign sw_prog_rd  = (addr_ff <= PROG_LAST) ? prog_mem[addr_ff] : ERASED;
	assign table_rd_val = (code_rd_addr <= PROG_LAST) ? prog_mem[code_rd_addr]
		: ERASED;

	// Program array write port.
	always_ff @(posedge pclk) begin
		if (er_busy) begin
			prog_mem[er_addr] <= ERASED;
		end else if (par_prog_we) begin
			prog_mem[par_addr] <= prog_mem[par_addr] & p0_s;
		end else if (sw_prog_we) begin
			prog_mem[addr_ff] <= prog_mem[addr_ff] & data_ff;
		end
	end

	// Data array write port; page erase clears four bytes at once.
	always_ff @(posedge pclk) begin
		if (er_busy) begin
			if (erase_data_ff && er_addr < DATA_END) begin
				data_mem[er_addr[11:0]] <= ERASED;
			end
		end else if (par_data_we) begin
			data_mem[par_addr[11:0]] <= data_mem[par_addr[11:0]] & p0_s;
		end else if (sw_data_we) begin
			data_mem[addr_ff[11:0]] <= data_mem[addr_ff[11:0]] & data_ff;
		end else if (sw_page_er) begin
			for (int i = 0; i < 4; i++) begin
				data_mem[{pg_idx, 2'(i)}] <= ERASED;
			end
		end
	end

	// Flags set independently; only the matching erase clears them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_ff       <= 1'b0;
			secure_ff     <= 1'b0;
			safe_ff       <= 1'b0;
			erase_data_ff <= 1'b0;
		end else begin
			if (er_start) begin
				lock_ff       <= 1'b0;
				secure_ff     <= 1'b0;
				erase_data_ff <= par_erase;
			end else if (par_secw) begin
				lock_ff   <= lock_ff | p0_s[SEC_LOCK];
				secure_ff <= secure_ff | p0_s[SEC_SECURE];
			end else if (sw_secw) begin
				lock_ff   <= lock_ff | data_ff[SEC_LOCK];
				secure_ff <= secure_ff | data_ff[SEC_SECURE];
			end
			// Serial code erase leaves serial-safe standing.
			if (par_erase) begin
				safe_ff <= 1'b0;
			end else if (par_secw) begin
				safe_ff <= safe_ff | p0_s[SEC_SAFE];
			end else if (sw_secw) begin
				safe_ff <= safe_ff | data_ff[SEC_SAFE];
			end
		end
	end

	// Download entry is judged once, at the release of the reset pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dl_mode_ff <= 1'b0;
		end else if (rst_rise) begin
			dl_mode_ff <= ~pse_s & ~safe_ff;
		end else if (!rst_pin_s) begin
			dl_mode_ff <= 1'b0;
		end
	end
	assign serial_download_mode = dl_mode_ff;

	// Parallel read value; secure hides code bytes.
	assign par_rd_val = (par_op == OP_SIG) ? SIGNATURE
		: (par_op == OP_SECR) ? {5'h00, safe_ff, secure_ff, lock_ff}
		: (par_op == OP_READ && par_code) ? (secure_ff ? 8'h00 : par_prog_rd)
		: (par_op == OP_READ && par_data_in) ? data_mem[par_addr[11:0]]
		: ERASED;

	// Port 0 drives only after a read-type operation while enabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_out <= 8'h00;
			port0_oe  <= 1'b0;
		end else if (!par_en_s) begin
			port0_oe <= 1'b0;
		end else if (par_go) begin
			port0_oe  <= (par_op == OP_SIG) | (par_op == OP_READ)
				| (par_op == OP_SECR);
			port0_out <= par_rd_val;
		end
	end

	// Table reads from running code; external fetch is blocked by secure.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_rd_data    <= 8'h00;
			code_rd_refused <= 1'b0;
		end else if (code_rd_req) begin
			code_rd_refused <= code_rd_ext & secure_ff;
			code_rd_data    <= (code_rd_ext & secure_ff) ? 8'h00
				: table_rd_val;
		end
	end

	// APB decode; no wait states, unmapped offsets answer with an error.
	logic        apb_acc, apb_hit, wr_addr, wr_data, wr_cmd;
	logic [5:0]  status_w;
	logic [31:0] rd_mux;

	assign apb_acc = psel & penable;
	assign apb_hit = (paddr == REG_ADDR) | (paddr == REG_DATA)
		| (paddr == REG_CMD) | (paddr == REG_STATUS);
	assign wr_addr = apb_acc & pwrite & (paddr == REG_ADDR);
	assign wr_data = apb_acc & pwrite & (paddr == REG_DATA);
	assign wr_cmd  = apb_acc & pwrite & (paddr == REG_CMD);
	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~apb_hit;

	assign status_w[ST_ERR]    = err_ff;
	assign status_w[ST_BUSY]   = er_busy | cmd_go_ff;
	assign status_w[ST_DL]     = dl_mode_ff;
	assign status_w[ST_LOCK]   = lock_ff;
	assign status_w[ST_SECURE] = secure_ff;
	assign status_w[ST_SAFE]   = safe_ff;

	assign rd_mux = (paddr == REG_ADDR) ? {16'h0000, addr_ff}
		: (paddr == REG_DATA) ? {24'h000000, data_ff}
		: (paddr == REG_CMD) ? {29'h00000000, cmd_ff}
		: (paddr == REG_STATUS) ? {26'h0000000, status_w}
		: 32'h00000000;

	// Read data is caught in the setup cycle so it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// Software registers; a command runs in the cycle after its write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff   <= 16'h0000;
			data_ff   <= 8'h00;
			cmd_ff    <= 3'h0;
			cmd_go_ff <= 1'b0;
			err_ff    <= 1'b0;
		end else begin
			cmd_go_ff <= wr_cmd;
			if (wr_cmd) begin
				cmd_ff <= pwdata[2:0];
			end
			if (wr_addr) begin
				addr_ff <= pwdata[15:0];
			end
			if (cmd_go_ff) begin
				err_ff <= sw_bad;
			end
			if (cmd_ex && cmd_ff == CMD_RD_DATA && sw_data_in) begin
				data_ff <= data_mem[addr_ff[11:0]];
			end else if (cmd_ex && cmd_ff == CMD_RD_PROG) begin
				data_ff <= sw_prog_rd;
			end else if (wr_data) begin
				data_ff <= pwdata[7:0];
			end
		end
	end

	// Checks on the protection and access behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_dl_reset;
		rst_rise && !pse_s;
	endsequence
	sequence s_par_erase;
		par_go && par_op == OP_ERASE;
	endsequence

	a_dl_entry: assert property (s_dl_reset ##0 !safe_ff |=> dl_mode_ff)
		else $error("Download reset did not enter download mode.");
	a_safe_reset: assert property (s_dl_reset ##0 safe_ff |=> !dl_mode_ff [*2])
		else $error("Serial-safe let download mode in.");
	a_dl_full: assert property (cmd_ex && cmd_ff == CMD_WR_PROG && dl_mode_ff
		&& addr_ff <= PROG_LAST |=> !err_ff)
		else $error("Download write refused inside program array.");
	a_top_guard: assert property (cmd_go_ff && cmd_ff == CMD_WR_PROG
		&& !dl_mode_ff && addr_ff > USER_DL_LAST |=> err_ff)
		else $error("User download reached the upper region.");
	a_low_user_download_mode: assert property (cmd_ex && cmd_ff == CMD_WR_PROG
		&& addr_ff <= USER_DL_LAST |=> !err_ff)
		else $error("User download refused in lower region.");
	a_range_read: assert property (code_rd_req && !code_rd_ext
		&& code_rd_addr > PROG_LAST |=> code_rd_data == ERASED)
		else $error("Read above program array returned data.");
	a_page_erase: assert property (sw_page_er |=>
		data_mem[{$past(pg_idx), 2'h3}] == ERASED)
		else $error("Page erase left a byte programmed.");
	a_sig_read: assert property (par_go && par_op == OP_SIG
		|=> port0_oe && port0_out == SIGNATURE)
		else $error("Signature read gave wrong port value.");
	a_lock_read: assert property (par_go && par_op == OP_READ && par_code
		&& lock_ff && !secure_ff |=> port0_out == $past(par_prog_rd))
		else $error("Lock blocked a parallel read.");
	a_secure_read: assert property (par_go && par_op == OP_READ && par_code
		&& secure_ff |=> port0_out == 8'h00)
		else $error("Secure leaked a code byte.");
	a_table_block: assert property (code_rd_req && code_rd_ext && secure_ff
		|=> code_rd_refused && code_rd_data == 8'h00)
		else $error("External table read passed under secure.");
	a_erase_clear: assert property (s_par_erase |=>
		!lock_ff && !secure_ff && !safe_ff && er_busy)
		else $error("Parallel code erase left a flag set.");
	a_flag_hold: assert property (!er_start |=>
		!$fell(lock_ff) && !$fell(secure_ff))
		else $error("Lock or secure cleared without code erase.");
	a_safe_keep: assert property (sw_erase && safe_ff |=> safe_ff)
		else $error("Serial code erase cleared serial-safe.");
	a_undef_op: assert property (par_go && par_op > OP_SECR |=> $stable(lock_ff)
		&& $stable(secure_ff) && $stable(safe_ff) && !er_busy)
		else $error("Undefined port code changed state.");
	a_sec_set: assert property (par_secw && p0_s == 8'h01
		|=> lock_ff && $stable(safe_ff) && $stable(secure_ff))
		else $error("Security write touched another flag.");
endmodule // fpa_top
`default_nettype wire

// ===== fpa_prog_model.sv
// Parallel programmer and reset-pin driver facing the access block.
`timescale 1ns/1ps
`default_nettype none
module fpa_prog_model (
	input  wire logic       pclk,
	input  wire logic [7:0] port0_out,
	input  wire logic       port0_oe,
	output logic            reset_pin_n,
	output logic            program_store_enable_pin,
	output logic            par_enable_pin,
	output logic            ale_pin,
	output logic [7:0]      port0_drv,
	output logic [7:0]      port1_in,
	output logic [7:0]      port2_in,
	output logic [7:0]      port3_in
);
	// Idle levels: the enable pin rests high, the strobe low.
	initial begin
		reset_pin_n = 1'b1;
		program_store_enable_pin = 1'b1;
		par_enable_pin = 1'b0;
		ale_pin = 1'b0;
		port0_drv = 8'h00;
		port1_in = 8'h00;
		port2_in = 8'h00;
		port3_in = 8'h00;
	end

	// Reset pulse; the enable pin is held long past release for sampling.
	task automatic reset_pulse(input logic pse);
		@(posedge pclk);
		program_store_enable_pin <= pse;
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge pclk);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge pclk);
		program_store_enable_pin <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	// One strobed operation; inputs stay put until the answer is taken.
	task automatic par_op(input logic [2:0] op, input logic code,
		input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		@(posedge pclk);
		par_enable_pin <= 1'b1;
		port3_in <= {3'h0, code, op, 1'b0};
		{port2_in, port1_in} <= a;
		port0_drv <= d;
		repeat (3) @(posedge pclk);
		ale_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		ale_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		q = port0_out;
		oe = port0_oe;
		// A released bus must not keep showing the last value.
		port0_drv <= ~d;
		// The block drives port 0 after a read until its enable drops,
		// so the enable falls between ops to free the bus for write data.
		par_enable_pin <= 1'b0;
	endtask

	// Leaves parallel programming mode.
	task automatic par_off();
		@(posedge pclk);
		par_enable_pin <= 1'b0;
	endtask
endmodule // fpa_prog_model
`default_nettype wire

// ===== tb_flash_program_access_security.sv
// Self-checking bench for the flash access and protection block.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_access_security;
	import fpa_pkg::*;
	localparam logic [7:0] SIG = 8'hA5; // Arbitrary signature value.
	logic             pclk = 1'b0;
	logic             presetn, psel, penable, pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, rd, st;
	logic             code_rd_req, code_rd_ext, er, oe;
	logic [15:0]      code_rd_addr;
	logic [7:0]       q;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, reset_pin_n, par_enable_pin;
	wire logic        program_store_enable_pin, ale_pin, port0_oe;
	wire logic        code_rd_refused, serial_download_mode;
	wire logic [7:0]  port0_in, port0_out, port0_drv, port1_in;
	wire logic [7:0]  port2_in, port3_in, code_rd_data;
	int               failures = 0;
	int               compares = 0;
	int               cycles = 0;

	fpa_top #(.ERASE_SPAN(4096), .SIGNATURE(SIG)) fpa_top_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .reset_pin_n,
		.program_store_enable_pin, .par_enable_pin, .ale_pin,
		.port0_in, .port0_out, .port0_oe, .port1_in, .port2_in,
		.port3_in, .code_rd_req, .code_rd_ext, .code_rd_addr,
		.code_rd_data, .code_rd_refused, .serial_download_mode);
	fpa_prog_model fpa_prog_model_inst (
		.pclk, .port0_out, .port0_oe, .reset_pin_n,
		.program_store_enable_pin, .par_enable_pin, .ale_pin,
		.port0_drv, .port1_in, .port2_in, .port3_in);
	// The block owns port 0 while port0_oe is high.
	assign port0_in = port0_oe ? port0_out : port0_drv;

	// Clock of 8 ns; a hang ends the run as a mismatch.
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_err(input string n, input logic e);
		chk(n, {31'h0, e}, {31'h0, st[ST_ERR]});
	endtask
	task automatic chk_st(input string n, input logic [5:0] e);
		chk(n, {26'h0, e}, {26'h0, st[5:0]});
	endtask

	// One APB transfer, held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle();
		do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
		st = rd;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [15:0] a,
		input logic [7:0] d);
		apb(1'b1, REG_ADDR, {16'h0, a});
		apb(1'b1, REG_DATA, {24'h0, d});
		apb(1'b1, REG_CMD, {29'h0, c});
		idle();
	endtask
	task automatic fetch(input logic [2:0] c, input logic [15:0] a);
		cmd(c, a, 8'h00);
		apb(1'b0, REG_DATA, 32'h0);
	endtask
	task automatic par(input logic [2:0] o, input logic c,
		input logic [15:0] a, input logic [7:0] d);
		fpa_prog_model_inst.par_op(o, c, a, d, q, oe);
	endtask
	task automatic table_rd(input logic x, input logic [15:0] a);
		@(posedge pclk);
		code_rd_req <= 1'b1;
		code_rd_ext <= x;
		code_rd_addr <= a;
		@(posedge pclk);
		code_rd_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic t_regs();
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_rst", 32'h0, rd);
		apb(1'b1, REG_ADDR, 32'h1234ABCD);
		apb(1'b0, REG_ADDR, 32'h0);
		chk("addr_rw", 32'h0000ABCD, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		$display("t_regs done");
	endtask

	task automatic t_dl();
		fpa_prog_model_inst.reset_pulse(1'b0);
		chk("dl_on", 32'h1, {31'h0, serial_download_mode});
		cmd(CMD_ERASE, 16'h0000, 8'h00);
		cmd(CMD_WR_PROG, 16'hF7FF, 8'h3C);
		chk_err("dl_top", 1'b0);
		cmd(CMD_WR_PROG, 16'hF800, 8'h3C);
		chk_err("above_top", 1'b1);
		fetch(CMD_RD_PROG, 16'hF800);
		chk("rd_above", {24'h0, ERASED}, rd);
		cmd(CMD_WR_PROG, 16'h0000, 8'h81);
		fetch(CMD_RD_PROG, 16'h0000);
		chk("rd_zero", 32'h81, rd);
		$display("t_dl done");
	endtask

	task automatic t_user();
		fpa_prog_model_inst.reset_pulse(1'b1);
		chk("dl_off", 32'h0, {31'h0, serial_download_mode});
		cmd(CMD_WR_PROG, 16'hE000, 8'h00);
		chk_err("user_top", 1'b1);
		cmd(CMD_WR_PROG, 16'hDFFF, 8'h00);
		chk_err("user_low", 1'b0);
		cmd(CMD_WR_PROG, 16'h0001, 8'h5A);
		fetch(CMD_RD_PROG, 16'h0001);
		chk("user_wr", 32'h5A, rd);
		$display("t_user done");
	endtask

	// Page erase, byte write, and a second write that can only clear bits.
	task automatic t_data();
		cmd(CMD_ER_PAGE, 16'h0FFD, 8'h00);
		cmd(CMD_WR_DATA, 16'h0FFE, 8'hA7);
		fetch(CMD_RD_DATA, 16'h0FFE);
		chk("data_wr", 32'hA7, rd);
		fetch(CMD_RD_DATA, 16'h0FFC);
		chk("page_erased", {24'h0, ERASED}, rd);
		cmd(CMD_WR_DATA, 16'h0FFE, 8'h5F);
		fetch(CMD_RD_DATA, 16'h0FFE);
		chk("no_erase_wr", 32'h07, rd);
		fetch(CMD_RD_DATA, DATA_END);
		chk_err("data_range", 1'b1);
		$display("t_data done");
	endtask

	task automatic t_par();
		par(OP_ERASE, 1'b0, 16'h0000, 8'h00);
		idle();
		par(OP_SIG, 1'b0, 16'h0000, 8'h00);
		chk("sig", {24'h0, SIG}, {24'h0, q});
		chk("sig_oe", 32'h1, {31'h0, oe});
		par(OP_PROG, 1'b1, 16'h0010, 8'hC3);
		par(OP_PROG, 1'b0, 16'h0020, 8'h96);
		par(OP_READ, 1'b0, 16'h0020, 8'h00);
		chk("par_data", 32'h96, {24'h0, q});
		par(OP_PROG, 1'b1, 16'hF800, 8'h00);
		par(OP_READ, 1'b1, 16'hF800, 8'h00);
		chk("par_above", {24'h0, ERASED}, {24'h0, q});
		for (int k = 6; k < 8; k++) begin
			par(3'(k), 1'b1, 16'h0010, 8'h00);
			chk("undef_oe", 32'h0, {31'h0, oe});
		end
		par(OP_READ, 1'b1, 16'h0010, 8'h00);
		chk("par_code", 32'hC3, {24'h0, q});
		$display("t_par done");
	endtask

	task automatic t_prot();
		// Command code 0 does nothing but clears the sticky error bit.
		cmd(3'h0, 16'h0000, 8'h00);
		chk_st("nop_cmd", 6'h00);
		par(OP_SECW, 1'b0, 16'h0000, 8'h01 << SEC_LOCK);
		idle();
		chk_st("lock_set", 6'h01 << ST_LOCK);
		par(OP_PROG, 1'b1, 16'h0010, 8'h00);
		par(OP_READ, 1'b1, 16'h0010, 8'h00);
		chk("lock_rd", 32'hC3, {24'h0, q});
		table_rd(1'b1, 16'h0010);
		chk("lock_tbl", 32'hC3, {24'h0, code_rd_data});
		par(OP_SECW, 1'b0, 16'h0000, 8'h01 << SEC_SECURE);
		idle();
		chk_st("sec_set", (6'h01 << ST_LOCK) | (6'h01 << ST_SECURE));
		par(OP_READ, 1'b1, 16'h0010, 8'h00);
		chk("sec_rd", 32'h00, {24'h0, q});
		table_rd(1'b1, 16'h0010);
		chk("sec_ext", 32'h1, {31'h0, code_rd_refused});
		table_rd(1'b0, 16'h0010);
		chk("sec_int", 32'h0, {31'h0, code_rd_refused});
		table_rd(1'b0, 16'hF800);
		chk("tbl_above", {24'h0, ERASED}, {24'h0, code_rd_data});
		par(OP_SECR, 1'b0, 16'h0000, 8'h00);
		chk("sec_byte", 32'h3, {29'h0, q[2:0]});
		par(OP_ERASE, 1'b0, 16'h0000, 8'h00);
		fpa_prog_model_inst.par_off();
		idle();
		chk_st("par_clear", 6'h00);
		$display("t_prot done");
	endtask

	task automatic t_safe();
		fpa_prog_model_inst.reset_pulse(1'b0);
		cmd(CMD_SEC_SET, 16'h0000, 8'h05);
		chk_st("safe_set", 6'h2C);
		cmd(CMD_ERASE, 16'h0000, 8'h00);
		chk_st("ser_erase", 6'h24);
		fpa_prog_model_inst.reset_pulse(1'b0);
		chk("safe_dl", 32'h0, {31'h0, serial_download_mode});
		par(OP_ERASE, 1'b0, 16'h0000, 8'h00);
		fpa_prog_model_inst.par_off();
		idle();
		chk_st("safe_clear", 6'h00);
		fpa_prog_model_inst.reset_pulse(1'b0);
		chk("dl_again", 32'h1, {31'h0, serial_download_mode});
		$display("t_safe done");
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		code_rd_req = 1'b0;
		code_rd_ext = 1'b0;
		code_rd_addr = 16'h0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_dl();
		t_user();
		t_data();
		t_par();
		t_prot();
		t_safe();
		end_of_test();
	end
endmodule // tb_flash_program_access_security
`default_nettype wire
